// ### bench/pdr_ctrl_chk.sv
// port assertions for the packet dram controller
`timescale 1ns/1ps
module pdr_ctrl_chk
  import pdr_pkg::*;
#(
  parameter int REFRESH_CYCLES = 40
) (
  // clock and reset
  input wire logic               clk_in,
  input wire logic               arst_n_in,
  // watched outputs
  input wire logic               req_ready_out,
  input wire logic               rd_valid_out,
  input wire logic               mem_reference_clock_out,
  input wire pdr_pkg::pdr_pins_s mem_pins_out,
  input wire logic               mem_data_bus_oe_out,
  input wire logic               refresh_pending_out
);
  int gap;
  // margin of two covers the set and clear steps of the pending flag
  int lim;
  assign lim = REFRESH_CYCLES + 2;
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!arst_n_in);
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) gap <= 0;
    else gap <= refresh_pending_out ? 0 : gap + 1;
  end
  a_pins_on_rise: assert property ($changed(mem_pins_out) |-> $rose(mem_reference_clock_out))
    else $error("pin change off reference rise");
  a_ref_toggles: assert property (mem_reference_clock_out |=> !mem_reference_clock_out)
    else $error("reference clock not divided");
  a_cbr_we_high: assert property ($fell(mem_pins_out.column_strobe_n)
    && mem_pins_out.row_strobe_n |-> mem_pins_out.write_enable_n)
    else $error("write enable low in refresh");
  a_cbr_no_addr: assert property ($fell(mem_pins_out.column_strobe_n)
    && mem_pins_out.row_strobe_n |=> $stable(mem_pins_out.addr)[*3])
    else $error("address moved in refresh");
  a_cbr_no_data: assert property (mem_pins_out.row_strobe_n
    && !mem_pins_out.column_strobe_n |-> !mem_data_bus_oe_out)
    else $error("data driven in refresh");
  a_bus_no_clash: assert property (mem_data_bus_oe_out |-> mem_pins_out.output_enable_n)
    else $error("data driven with memory output on");
  a_take_no_ref: assert property (req_ready_out |-> !refresh_pending_out)
    else $error("request taken with refresh pending");
  a_refresh_rate: assert property (gap <= lim)
    else $error("refresh request late");
  a_rd_pulse: assert property (rd_valid_out |=> !rd_valid_out)
    else $error("read valid longer than a cycle");
endmodule : pdr_ctrl_chk

bind pdr_ctrl pdr_ctrl_chk #(.REFRESH_CYCLES(REFRESH_CYCLES)) u_chk (
  .clk_in(clk_in), .arst_n_in(arst_n_in), .req_ready_out(req_ready_out),
  .rd_valid_out(rd_valid_out), .mem_reference_clock_out(mem_reference_clock_out),
  .mem_pins_out(mem_pins_out), .mem_data_bus_oe_out(mem_data_bus_oe_out),
  .refresh_pending_out(refresh_pending_out));

// ### bench/pdr_ctrl_tb.sv
// self-checking bench for the packet dram controller
`timescale 1ns/1ps
module pdr_ctrl_tb;
  import pdr_pkg::*;
  localparam int RC = 40;
  logic              clk_in = 1'b0;
  logic              arst_n_in = 1'b0;
  logic              req_valid_in = 1'b0;
  pdr_req_s          req_in = '0;
  logic              wr_valid_in = 1'b0;
  logic [DATA_W-1:0] wr_data_in = '0;
  logic [DATA_W-1:0] rd_data_out, dq_dut, dq_mem;
  logic              req_ready_out, wr_ready_out, rd_valid_out, ref_clk, dq_oe, pend, took;
  pdr_pins_s         pins;
  int                n_errors = 0;
  int                compares = 0;
  always #2.5 clk_in = ~clk_in;
  always @(posedge clk_in) took <= req_valid_in & req_ready_out;
  pdr_ctrl #(.REFRESH_CYCLES(RC), .FIFO_DEPTH(8)) u_dut (.clk_in, .arst_n_in, .req_valid_in,
    .req_ready_out, .req_in, .wr_valid_in, .wr_ready_out, .wr_data_in, .rd_valid_out,
    .rd_data_out, .mem_reference_clock_out(ref_clk), .mem_pins_out(pins),
    .mem_data_bus_in(dq_mem), .mem_data_bus_out(dq_dut), .mem_data_bus_oe_out(dq_oe),
    .refresh_pending_out(pend));
  pdr_mem_model u_mem (.clk_in, .pins_in(pins), .dq_in(dq_dut), .dq_out(dq_mem));
  function automatic logic [DATA_W-1:0] word(input int i);
    return 36'h9a5a50000 + DATA_W'(i);
  endfunction : word
  task automatic chk(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic close_out();
    $display("mismatches %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : close_out
  task automatic t_fill();
    for (int i = 0; i < 8; i++) begin
      @(negedge clk_in);
      chk(wr_ready_out, 1'b1);
      wr_valid_in = 1'b1;
      wr_data_in = word(i);
    end
    @(negedge clk_in);
    wr_valid_in = 1'b0;
    chk(wr_ready_out, 1'b0); // full fifo refuses
  endtask : t_fill
  task automatic t_burst(input logic wr);
    int n;
    int k;
    @(negedge clk_in);
    req_valid_in = 1'b1;
    req_in = '{write: wr, ext: 3'h5, row: 8'h5c, col: 8'h10, count: 8'h08};
    for (n = 0; n < 400 && took !== 1'b1; n++) @(negedge clk_in);
    req_valid_in = 1'b0;
    if (n == 400) begin n_errors++; close_out(); end
    k = 0;
    for (n = 0; n < 3000 && k < 8; n++) begin
      @(negedge clk_in);
      if (wr && ref_clk === 1'b1 && pins.write_enable_n === 1'b0) begin
        chk(dq_dut, word(k));
        k++;
      end
      if (!wr && rd_valid_out === 1'b1) begin
        chk(rd_data_out, word(k));
        k++;
      end
    end
    if (k < 8) begin n_errors++; close_out(); end
    chk(u_mem.row_l, 8'h5c);
    chk(u_mem.ext_l, 3'h5);
  endtask : t_burst
  task automatic t_refresh();
    int n;
    int gap;
    gap = -1;
    for (n = 0; n < 400 && gap < 0; n++) begin
      @(negedge clk_in);
      if (pend === 1'b1 && gap < -1) gap = 0;
      if (pend === 1'b0) gap = -2;
    end
    for (n = 0; n < 400 && (gap == 0 || pend === 1'b1); n++) begin
      @(negedge clk_in);
      gap++;
    end
    for (n = 0; n < 400 && pend !== 1'b1; n++) begin
      @(negedge clk_in);
      gap++;
    end
    chk(gap, RC);
    chk(u_mem.n_ref > 0, 1'b1);
  endtask : t_refresh
  initial begin
    repeat (16) @(negedge clk_in);
    arst_n_in = 1'b1;
    t_fill();
    t_burst(1'b1);
    t_burst(1'b0);
    t_refresh();
    close_out();
  end
endmodule : pdr_ctrl_tb

// ### bench/pdr_mem_model.sv
// behavioural edo dram on the far side of the controller
`timescale 1ns/1ps
module pdr_mem_model
  import pdr_pkg::*;
(
  // clock
  input  wire logic                       clk_in,
  // pins from the controller
  input  wire pdr_pkg::pdr_pins_s         pins_in,
  input  wire logic [pdr_pkg::DATA_W-1:0] dq_in,
  // read data back
  output logic [pdr_pkg::DATA_W-1:0]      dq_out
);
  // one row is enough here, so words are kept by column only
  logic [DATA_W-1:0] mem [0:255];
  logic [ADDR_W-1:0] row_l = '0;
  logic [ADDR_W-1:0] col_l = '0;
  logic [EXT_W-1:0]  ext_l = '0;
  logic              ras_q = 1'b1;
  logic              cas_q = 1'b1;
  logic [DATA_W-1:0] last  = '0;
  int                n_ref = 0;
  always @(posedge clk_in) begin
    ras_q <= pins_in.row_strobe_n;
    cas_q <= pins_in.column_strobe_n;
    if (!pins_in.row_strobe_n && ras_q) begin
      if (!pins_in.column_strobe_n) n_ref <= n_ref + 1;
      else row_l <= pins_in.addr;
      if (pins_in.column_strobe_n) ext_l <= pins_in.ext;
    end
    if (!pins_in.column_strobe_n && cas_q && !pins_in.row_strobe_n) begin
      col_l <= pins_in.addr;
      if (!pins_in.write_enable_n) mem[pins_in.addr] <= dq_in;
    end
    if (!pins_in.output_enable_n) last <= dq_out;
  end
  // released bus shows the inverse of the last word, never a stale match
  always_comb dq_out = (!pins_in.output_enable_n && !pins_in.row_strobe_n)
                       ? mem[col_l] : ~last;
endmodule : pdr_mem_model

// ### include/pdr_pkg.sv
// shared constants and carriers for the packet dram refresh and burst controller
package pdr_pkg;
  localparam int          CLK_MHZ         = 200;
  localparam real         REFRESH_US      = 10.22;
  localparam int          REFRESH_CYC     = int'(REFRESH_US * CLK_MHZ);
  localparam int          DATA_W          = 36;
  localparam int          ADDR_W          = 8;
  localparam int          EXT_W           = 3;
  localparam int          REF_DIV         = 2;
  localparam int          BURST_W         = 8;
  localparam logic [ADDR_W-1:0] ADDR_RESET = 8'h00;
  localparam logic [EXT_W-1:0]  EXT_RESET  = 3'h0;

  typedef enum logic [3:0] {
    PDR_IDLE, PDR_ROW, PDR_COL, PDR_STROBE, PDR_NEXT, PDR_CLOSE,
    PDR_REF_CAS, PDR_REF_RAS, PDR_REF_END
  } pdr_state_e;

  // one burst request: row, extension bits, starting column, word count, direction
  typedef struct packed {
    logic               write;
    logic [EXT_W-1:0]   ext;
    logic [ADDR_W-1:0]  row;
    logic [ADDR_W-1:0]  col;
    logic [BURST_W-1:0] count;
  } pdr_req_s;

  // memory pin group
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [EXT_W-1:0]  ext;
    logic              row_strobe_n;
    logic              column_strobe_n;
    logic              write_enable_n;
    logic              output_enable_n;
  } pdr_pins_s;
endpackage : pdr_pkg

// ### verilog/pdr_ctrl.sv
// packet dram controller: periodic cas-first refresh and burst frame access
`timescale 1ns/1ps
module pdr_ctrl
  import pdr_pkg::*;
#(
  parameter int REFRESH_CYCLES = REFRESH_CYC,
  parameter int FIFO_DEPTH     = 8
) (
  // clock and reset
  input  wire logic              clk_in,
  input  wire logic              arst_n_in,
  // burst request
  input  wire logic              req_valid_in,
  output logic                   req_ready_out,
  input  wire pdr_pkg::pdr_req_s req_in,
  // write data from the frame source
  input  wire logic              wr_valid_in,
  output logic                   wr_ready_out,
  input  wire logic [pdr_pkg::DATA_W-1:0] wr_data_in,
  // read data to the frame sink
  output logic                   rd_valid_out,
  output logic [pdr_pkg::DATA_W-1:0] rd_data_out,
  // memory pins
  output logic                   mem_reference_clock_out,
  output pdr_pkg::pdr_pins_s     mem_pins_out,
  input  wire logic [pdr_pkg::DATA_W-1:0] mem_data_bus_in,
  output logic [pdr_pkg::DATA_W-1:0] mem_data_bus_out,
  output logic                   mem_data_bus_oe_out,
  // status
  output logic                   refresh_pending_out
);
  localparam int RW = $clog2(REFRESH_CYCLES + 1);
  localparam int DW = $clog2(REF_DIV);

  pdr_state_e              state;
  pdr_req_s                cur;
  logic [RW-1:0]           ref_cnt;
  logic [DW-1:0]           div_cnt;
  logic                    ref_rise;
  logic                    ref_due;
  logic                    fifo_valid;
  logic [DATA_W-1:0]       fifo_data;
  logic                    fifo_take;
  logic [DATA_W-1:0]       rd_sync1;
  logic [DATA_W-1:0]       rd_sync2;
  logic                    rd_cap1;
  logic                    rd_cap2;

  // column advance shared by the pin update and the held request
  function automatic logic [ADDR_W-1:0] col_step(input logic [ADDR_W-1:0] col);
    return col + 1'b1;
  endfunction : col_step

  // write words wait here so the source can run ahead of the row opening
  pdr_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) u_wr_fifo (
    .clk_in        (clk_in),
    .arst_n_in     (arst_n_in),
    .in_valid_in   (wr_valid_in),
    .in_ready_out  (wr_ready_out),
    .in_data_in    (wr_data_in),
    .out_valid_out (fifo_valid),
    .out_ready_in  (fifo_take),
    .out_data_out  (fifo_data)
  );

  // divided reference clock; all pin updates happen on the same clock edge as its rise
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      div_cnt                 <= '0;
      mem_reference_clock_out <= 1'b0;
    end else begin
      div_cnt                 <= (div_cnt == DW'(REF_DIV-1)) ? '0 : div_cnt + 1'b1;
      mem_reference_clock_out <= (div_cnt == DW'(REF_DIV-1));
    end
  end
  assign ref_rise = (div_cnt == DW'(REF_DIV-1));

  // fixed-rate refresh timer, runs regardless of traffic
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      ref_cnt <= '0;
    end else if (ref_cnt == RW'(REFRESH_CYCLES - 1)) begin
      ref_cnt <= '0;
    end else begin
      ref_cnt <= ref_cnt + 1'b1;
    end
  end
  assign ref_due = (ref_cnt == RW'(REFRESH_CYCLES - 1));

  // pending flag: a new tick wins over the clear of the served one
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      refresh_pending_out <= 1'b0;
    end else if (ref_due) begin
      refresh_pending_out <= 1'b1;
    end else if (ref_rise && state == PDR_REF_END) begin
      refresh_pending_out <= 1'b0;
    end
  end

  // write path pops only when a write word goes onto the pins
  assign fifo_take = ref_rise && state == PDR_COL && cur.write && fifo_valid;

  // ready is looked ahead one cycle so the port comes from a flop; the state cannot
  // move in the cycle before a reference rise, so only a new tick can spoil the grant.
  // limitation: this look-ahead needs a divide of two or more
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      req_ready_out <= 1'b0;
    end else begin
      req_ready_out <= (div_cnt == DW'(REF_DIV-2)) && state == PDR_IDLE
                       && !refresh_pending_out && !ref_due;
    end
  end

  // sequencer; state and pins move only on reference clock edges
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      state               <= PDR_IDLE;
      cur                 <= '0;
      mem_pins_out        <= '{ADDR_RESET, EXT_RESET, 1'b1, 1'b1, 1'b1, 1'b1};
      mem_data_bus_out    <= '0;
      mem_data_bus_oe_out <= 1'b0;
    end else if (ref_rise) begin
      case (state)
        PDR_IDLE: begin
          if (refresh_pending_out) begin
            mem_pins_out.column_strobe_n <= 1'b0;
            mem_pins_out.write_enable_n  <= 1'b1;
            state <= PDR_REF_CAS;
          end else if (req_valid_in) begin
            cur               <= req_in;
            mem_pins_out.addr <= req_in.row;
            mem_pins_out.ext  <= req_in.ext;
            state             <= PDR_ROW;
          end
        end
        PDR_ROW: begin
          // row address stays put across the strobe fall so the memory can latch it
          mem_pins_out.row_strobe_n <= 1'b0;
          state                     <= PDR_NEXT;
        end
        PDR_NEXT: begin
          mem_pins_out.addr <= cur.col;
          state             <= PDR_COL;
        end
        PDR_COL: begin
          if (cur.write) begin
            if (fifo_valid) begin
              mem_data_bus_out             <= fifo_data;
              mem_data_bus_oe_out          <= 1'b1;
              mem_pins_out.write_enable_n  <= 1'b0;
              mem_pins_out.column_strobe_n <= 1'b0;
              state                        <= PDR_STROBE;
            end
          end else begin
            mem_pins_out.output_enable_n <= 1'b0;
            mem_pins_out.column_strobe_n <= 1'b0;
            state                        <= PDR_STROBE;
          end
        end
        PDR_STROBE: begin
          mem_pins_out.column_strobe_n <= 1'b1;
          mem_pins_out.write_enable_n  <= 1'b1;
          cur.count                    <= cur.count - 1'b1;
          mem_pins_out.addr            <= col_step(cur.col);
          cur.col                      <= col_step(cur.col);
          state <= (cur.count <= BURST_W'(1)) ? PDR_CLOSE : PDR_COL;
        end
        PDR_CLOSE: begin
          mem_pins_out.row_strobe_n    <= 1'b1;
          mem_pins_out.output_enable_n <= 1'b1;
          mem_data_bus_oe_out          <= 1'b0;
          state                        <= PDR_IDLE;
        end
        PDR_REF_CAS: begin
          mem_pins_out.row_strobe_n <= 1'b0;
          state                     <= PDR_REF_RAS;
        end
        PDR_REF_RAS: begin
          mem_pins_out.column_strobe_n <= 1'b1;
          mem_pins_out.row_strobe_n    <= 1'b1;
          state                        <= PDR_REF_END;
        end
        default: begin
          state <= PDR_IDLE;
        end
      endcase
    end
  end

  // read data passes two flops from the pins before use; strobe marks capture
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rd_sync1     <= '0;
      rd_sync2     <= '0;
      rd_cap1      <= 1'b0;
      rd_cap2      <= 1'b0;
      rd_valid_out <= 1'b0;
      rd_data_out  <= '0;
    end else begin
      rd_sync1     <= mem_data_bus_in;
      rd_sync2     <= rd_sync1;
      rd_cap1      <= ref_rise && state == PDR_STROBE && !cur.write;
      rd_cap2      <= rd_cap1;
      rd_valid_out <= rd_cap2;
      rd_data_out  <= rd_cap2 ? rd_sync2 : rd_data_out;
    end
  end
endmodule : pdr_ctrl

// ### verilog/pdr_fifo.sv
// parameterised valid/ready fifo for frame words
`timescale 1ns/1ps
module pdr_fifo #(
  parameter int WIDTH = 36,
  parameter int DEPTH = 8
) (
  // clock and reset
  input  wire logic             clk_in,
  input  wire logic             arst_n_in,
  // fill side
  input  wire logic             in_valid_in,
  output logic                  in_ready_out,
  input  wire logic [WIDTH-1:0] in_data_in,
  // drain side
  output logic                  out_valid_out,
  input  wire logic             out_ready_in,
  output logic [WIDTH-1:0]      out_data_out
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      used;
  logic             push;
  logic             pop;

  assign push          = in_valid_in && (used != (AW+1)'(DEPTH));
  assign pop           = out_valid_out && out_ready_in;
  assign in_ready_out  = used != (AW+1)'(DEPTH);
  assign out_valid_out = used != '0;
  assign out_data_out  = mem[rd_ptr];

  always_ff @(posedge clk_in) begin
    if (push) begin
      mem[wr_ptr] <= in_data_in;
    end
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      used   <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
      end
      used <= used + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : pdr_fifo
